// *** rtl/rptc_pkg.sv ***
// Purpose: Shared constants and types of the receive port timestamp capture unit.
// Assumes: 100 MHz core clock, 8-bit register port.
// Notes: Every offset, field position and step count lives here, with the config, control and line reset values.
`default_nettype none
package rptc_pkg;
    // Register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_CONFIG = 8'h25;
    localparam logic [7:0] ADDR_CONTROL = 8'h26;
    localparam logic [7:0] ADDR_LINE_HI = 8'h27;
    localparam logic [7:0] ADDR_LINE_LO = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h29;
    localparam logic [7:0] ADDR_STAMP_BASE = 8'h2a;
    localparam logic [7:0] ADDR_STAMP_LAST = 8'h31;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h34;
    localparam logic [7:0] ADDR_INT_MASK = 8'h35;
    // Reset values
    localparam logic [7:0] RESET_CONFIG = 8'h00;
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [15:0] RESET_LINE = 16'h0000;
    // Field positions
    localparam int SYNC_EDGE_BIT = 6;
    localparam int HOLD_BIT = 4;
    localparam int READY_BIT = 4;
    localparam int EVT_READY_BIT = 0;
    localparam int EVT_SYNC_BIT = 1;
    // Writable bits; reserved bits always read zero
    localparam logic [7:0] CONFIG_WMASK = 8'h7b;
    localparam logic [7:0] CONTROL_WMASK = 8'h1f;
    localparam logic [7:0] INT_WMASK = 8'h03;
    // Step timing: the times in ps, the counts derived from the clock period
    localparam int CLK_PERIOD_PS = 10000;
    localparam int STEP0_PS = 40000;
    localparam int STEP1_PS = 80000;
    localparam int STEP2_PS = 160000;
    localparam int STEP3_PS = 1000000;
    localparam logic [6:0] STEP0_CYC = 7'((STEP0_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [6:0] STEP1_CYC = 7'((STEP1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [6:0] STEP2_CYC = 7'((STEP2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [6:0] STEP3_CYC = 7'((STEP3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int NUM_PORTS = 4;

    // Capture configuration register layout
    typedef struct packed {
        logic rsvd7;
        logic sync_edge_select;
        logic [1:0] count_step_select;
        logic early_ready_select;
        logic rsvd2;
        logic free_count_select;
        logic capture_event_select;
    } rptc_config_type;

    // Capture control register layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic capture_hold;
        logic [3:0] port_capture_on;
    } rptc_control_type;

    // Video timing events from one receive port
    typedef struct packed {
        logic line_start;
        logic frame_start;
    } rptc_port_evt_type;
endpackage
`default_nettype wire

// *** rtl/rptc_step_timer.sv ***
// Purpose: Timestamp counter advancing once per selected resolution step.
// Assumes: Restart is a one-cycle pulse from the frame-sync edge detector.
// Notes: The prescaler restarts together with the count so steps stay aligned.
`default_nettype none
module rptc_step_timer
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_restart,
    input wire logic [1:0] i_step_sel,
    // Count
    output logic [15:0] o_count
);
    typedef struct packed {
        logic [6:0] prescale;
        logic [15:0] count;
    } rptc_timer_state_type;

    rptc_timer_state_type st;
    rptc_timer_state_type next_st;
    logic [6:0] step_last;

    // R2: step length select
    always_comb
    begin
        case (i_step_sel)
            2'h0: step_last = rptc_pkg::STEP0_CYC - 7'h01;
            2'h1: step_last = rptc_pkg::STEP1_CYC - 7'h01;
            2'h2: step_last = rptc_pkg::STEP2_CYC - 7'h01;
            default: step_last = rptc_pkg::STEP3_CYC - 7'h01;
        endcase
    end

    // R14: restart on edge, else count per step
    always_comb
    begin
        next_st = st;
        if (i_restart)
        begin
            next_st.prescale = 7'h00;
            next_st.count = 16'h0000;
        end
        else if (st.prescale >= step_last)
        begin
            next_st.prescale = 7'h00;
            next_st.count = st.count + 16'h0001; // Wraps silently
        end
        else
        begin
            next_st.prescale = st.prescale + 7'h01;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_count = st.count;

    property p_restart_zero;
        @(posedge i_clk) disable iff (!i_nrst)
        i_restart |=> (o_count == 16'h0000) && (st.prescale == 7'h00);
    endproperty
    a_restart_zero: assert property (p_restart_zero) // R14
        else $error("count not zero after restart");

    property p_step_80ns;
        @(posedge i_clk) disable iff (!i_nrst)
        (!i_restart && i_step_sel == 2'h1 && st.prescale == 7'h07)
        |=> (o_count == $past(o_count) + 16'h0001);
    endproperty
    a_step_80ns: assert property (p_step_80ns) // R2
        else $error("80ns step did not advance after eight cycles");

    property p_hold_between;
        @(posedge i_clk) disable iff (!i_nrst)
        (!i_restart && st.prescale < step_last) |=> $stable(o_count);
    endproperty
    a_hold_between: assert property (p_hold_between) // R2
        else $error("count moved inside a step");
endmodule
`default_nettype wire

// *** rtl/rptc_port_capture.sv ***
// Purpose: Line tracking and 16-bit timestamp capture for one receive port.
// Assumes: Line and frame start are one-cycle pulses, synchronous to the clock.
// Notes: A capture in the same cycle as a valid clear keeps the valid flag set.
`default_nettype none
module rptc_port_capture
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Video timing of this port
    input wire rptc_pkg::rptc_port_evt_type i_evt,
    // Settings
    input wire logic i_enable,
    input wire logic i_hold,
    input wire logic i_frame_mode,
    input wire logic i_free,
    input wire logic [15:0] i_line_num,
    input wire logic [15:0] i_time,
    input wire logic i_clear_valid,
    // Captured value
    output logic [15:0] o_stamp,
    output logic o_valid
);
    typedef struct packed {
        logic [15:0] line;
        logic armed;
        logic [15:0] stamp;
        logic valid;
    } rptc_port_state_type;

    rptc_port_state_type st;
    rptc_port_state_type next_st;
    logic [15:0] line_next;
    logic cap_now;

    // R10: line tracking and frame-start arming
    always_comb
    begin
        next_st = st;
        line_next = st.line + 16'h0001;
        cap_now = 1'b0;
        if (i_evt.frame_start)
        begin
            next_st.line = 16'h0000;
            next_st.armed = 1'b0;
            // R5: frame start capture
            cap_now = i_frame_mode && (!i_free || st.armed);
        end
        else if (i_evt.line_start)
        begin
            next_st.line = line_next;
            // R10: line start capture at set line
            cap_now = !i_frame_mode && (line_next == i_line_num);
            if (line_next == i_line_num)
                next_st.armed = 1'b1;
        end
        // R8: disabled port does not capture
        // R15: hold blocks overwriting
        cap_now = cap_now && i_enable && !i_hold;
        if (i_clear_valid)
            next_st.valid = 1'b0;
        if (cap_now)
        begin
            next_st.stamp = i_time;
            next_st.valid = 1'b1; // Capture wins over clear
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_stamp = st.stamp;
    assign o_valid = st.valid;

    property p_hold_keeps;
        @(posedge i_clk) disable iff (!i_nrst)
        i_hold |=> $stable(o_stamp);
    endproperty
    a_hold_keeps: assert property (p_hold_keeps) // R15
        else $error("stamp changed while held");

    property p_disabled_keeps;
        @(posedge i_clk) disable iff (!i_nrst)
        !i_enable |=> $stable(o_stamp);
    endproperty
    a_disabled_keeps: assert property (p_disabled_keeps) // R8
        else $error("disabled port captured");

    property p_frame_capture;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_evt.frame_start && i_frame_mode && !i_free && i_enable && !i_hold)
        |=> o_valid && (o_stamp == $past(i_time));
    endproperty
    a_frame_capture: assert property (p_frame_capture) // R5
        else $error("frame start capture missed");
endmodule
`default_nettype wire

// *** rtl/rptc_top.sv ***
// Purpose: Four-port timestamp capture unit with register port and interrupt.
// Assumes: All inputs synchronous to i_clk; read data stands one cycle after the strobe.
// Notes: Software sets the hold bit, reads stamps, then clears the hold bit.
// Functional notes
// R1: Frame-sync active edge is rising when the edge select is 0, falling when 1.
// R2: Step select codes 00, 01, 10, 11 give 40ns, 80ns, 160ns and 1.0us per count.
// R3: With early ready set, ready rises as soon as every enabled port has a stamp.
// R4: Free-count select 0 gives frame-sync referenced counting, 1 gives free counting.
// R5: Capture event select 0 captures at a line start, 1 at a frame start.
// R6: Writing 1 to the hold bit freezes all stamps and clears the ready flag at once.
// R7: Software clears the hold bit after reading; capture stays stopped until then.
// R8: Each port has its own capture enable in control bits 0 to 3; disabled ports never capture.
// R9: Config and control reset to zero and their reserved bits read as zero.
// R10: Line mode captures at the 16-bit line number; free frame mode arms on that line.
// R11: A readable ready flag shows stamps may be read and clears when hold is set.
// R12: A read-only valid flag per port shows that its stamp was captured.
// R13: Each 16-bit stamp is read as separate upper and lower bytes.
// R14: In frame-sync mode the count restarts on each active edge; free counting never restarts.
// R15: While hold is set no capture overwrites a stored stamp.
`default_nettype none
module rptc_top
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Video timing from the receive ports
    input wire rptc_pkg::rptc_port_evt_type [3:0] i_port_evt,
    input wire logic i_frame_sync,
    // Interrupt
    output logic o_irq
);
    typedef struct packed {
        rptc_pkg::rptc_config_type cfg;
        rptc_pkg::rptc_control_type ctl;
        logic [15:0] line_num;
        logic sync_prev;
        logic ready;
        logic [7:0] int_status;
        logic [7:0] int_mask;
        logic [7:0] rdata;
        logic irq;
    } rptc_top_state_type;

    rptc_top_state_type st;
    rptc_top_state_type next_st;

    // Port capture results
    logic [3:0][15:0] stamp;
    logic [3:0] valid;
    logic [15:0] count;

    // Derived strobes
    logic sync_edge;
    logic timer_restart;
    logic hold_set;
    logic hold_release;
    logic clear_valid;
    logic all_valid;
    logic [7:0] events;
    logic [2:0] stamp_sel;
    logic [15:0] stamp_word;
    logic [7:0] rd_value;

    // R1: active edge chosen by edge select
    always_comb
    begin
        if (st.cfg.sync_edge_select)
            sync_edge = st.sync_prev && !i_frame_sync;
        else
            sync_edge = !st.sync_prev && i_frame_sync;
    end

    // R4: only frame-sync mode restarts the counter
    assign timer_restart = sync_edge && !st.cfg.free_count_select;

    // Shared time base for all ports
    rptc_step_timer u_timer
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_restart(timer_restart),
        .i_step_sel(st.cfg.count_step_select),
        .o_count(count)
    );

    // R6: hold edges from software writes
    assign hold_set = i_wr && (i_addr == rptc_pkg::ADDR_CONTROL)
        && i_wdata[rptc_pkg::HOLD_BIT];
    assign hold_release = i_wr && (i_addr == rptc_pkg::ADDR_CONTROL)
        && !i_wdata[rptc_pkg::HOLD_BIT] && st.ctl.capture_hold;

    // A new capture round starts at each counter restart outside hold or when hold is released
    assign clear_valid = (timer_restart && !st.ctl.capture_hold) || hold_release;

    // One capture unit per receive port
    genvar p;
    generate
        for (p = 0; p < rptc_pkg::NUM_PORTS; p++)
        begin : g_port
            rptc_port_capture u_port
            (
                .i_clk(i_clk),
                .i_nrst(i_nrst),
                .i_evt(i_port_evt[p]),
                .i_enable(st.ctl.port_capture_on[p]),
                .i_hold(st.ctl.capture_hold),
                .i_frame_mode(st.cfg.capture_event_select),
                .i_free(st.cfg.free_count_select),
                .i_line_num(st.line_num),
                .i_time(count),
                .i_clear_valid(clear_valid),
                .o_stamp(stamp[p]),
                .o_valid(valid[p])
            );
        end
    endgenerate

    // Every enabled port holds a stamp; no enabled port means never ready
    assign all_valid = (&(valid | ~st.ctl.port_capture_on)) && (|st.ctl.port_capture_on);

    // R13: stamp pair select, upper byte at the even offset
    assign stamp_sel = 3'(i_addr - rptc_pkg::ADDR_STAMP_BASE);
    assign stamp_word = stamp[stamp_sel[2:1]];

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_value = 8'h00;
        case (i_addr)
            // R9: reserved bits are never stored, so read zero
            rptc_pkg::ADDR_CONFIG: rd_value = st.cfg;
            rptc_pkg::ADDR_CONTROL: rd_value = st.ctl;
            rptc_pkg::ADDR_LINE_HI: rd_value = st.line_num[15:8];
            rptc_pkg::ADDR_LINE_LO: rd_value = st.line_num[7:0];
            // R11: ready flag and R12: per-port valid flags
            rptc_pkg::ADDR_STATUS: rd_value = {3'h0, st.ready, valid};
            rptc_pkg::ADDR_INT_STATUS: rd_value = st.int_status;
            rptc_pkg::ADDR_INT_MASK: rd_value = st.int_mask;
            default:
            begin
                // R13: upper and lower byte reads
                if (i_addr >= rptc_pkg::ADDR_STAMP_BASE && i_addr <= rptc_pkg::ADDR_STAMP_LAST)
                    rd_value = stamp_sel[0] ? stamp_word[7:0] : stamp_word[15:8];
            end
        endcase
    end

    // Next-state logic of registers, ready flag and interrupt
    always_comb
    begin
        next_st = st;
        events = 8'h00;
        next_st.sync_prev = i_frame_sync;

        // Register writes
        if (i_wr)
        begin
            case (i_addr)
                rptc_pkg::ADDR_CONFIG: next_st.cfg = i_wdata & rptc_pkg::CONFIG_WMASK;
                // R7: capture resumes only once hold is written back to 0
                rptc_pkg::ADDR_CONTROL: next_st.ctl = i_wdata & rptc_pkg::CONTROL_WMASK;
                // R10: line number kept as two bytes
                rptc_pkg::ADDR_LINE_HI: next_st.line_num[15:8] = i_wdata;
                rptc_pkg::ADDR_LINE_LO: next_st.line_num[7:0] = i_wdata;
                rptc_pkg::ADDR_INT_MASK: next_st.int_mask = i_wdata & rptc_pkg::INT_WMASK;
                default: next_st.int_mask = st.int_mask;
            endcase
        end

        // Ready flag
        if (hold_set || st.ctl.capture_hold)
        begin
            // R6: freeze clears ready in the same write
            // R11: ready stays low while held
            next_st.ready = 1'b0;
        end
        else if (timer_restart)
        begin
            // Normal mode reports the finished round at the edge closing it
            next_st.ready = !st.cfg.early_ready_select && all_valid;
        end
        else if ((st.cfg.early_ready_select || st.cfg.free_count_select) && all_valid)
        begin
            // R3: early ready once all enabled ports hold a stamp
            next_st.ready = 1'b1;
        end

        // Events: ready rising and active frame-sync edge
        events[rptc_pkg::EVT_READY_BIT] = next_st.ready && !st.ready;
        events[rptc_pkg::EVT_SYNC_BIT] = sync_edge;

        // Write one to clear; a new event in the same cycle wins
        if (i_wr && i_addr == rptc_pkg::ADDR_INT_STATUS)
            next_st.int_status = st.int_status & ~(i_wdata & rptc_pkg::INT_WMASK);
        next_st.int_status = next_st.int_status | events;

        // Level interrupt from a flop so the output never glitches
        next_st.irq = |(next_st.int_status & next_st.int_mask);

        // Read data stands only in the cycle after the strobe
        next_st.rdata = i_rd ? rd_value : 8'h00;
    end

    // State register; R9: all-zero reset of config and control
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st <= '0;
            st.cfg <= rptc_pkg::RESET_CONFIG;
            st.ctl <= rptc_pkg::RESET_CONTROL;
            st.line_num <= rptc_pkg::RESET_LINE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_irq = st.irq;

    // Helper: a write of the hold bit
    sequence s_hold_write;
        hold_set;
    endsequence

    sequence s_ready_low_two;
        !st.ready [*2];
    endsequence

    property p_hold_clears_ready;
        @(posedge i_clk) disable iff (!i_nrst)
        s_hold_write |=> s_ready_low_two;
    endproperty
    a_hold_clears_ready: assert property (p_hold_clears_ready) // R6
        else $error("ready not cleared by hold write");

    property p_rising_edge;
        @(posedge i_clk) disable iff (!i_nrst)
        (!st.cfg.sync_edge_select && !st.cfg.free_count_select
            && $rose(i_frame_sync)) |-> timer_restart;
    endproperty
    a_rising_edge: assert property (p_rising_edge) // R1
        else $error("rising frame-sync edge not taken");

    property p_falling_only;
        @(posedge i_clk) disable iff (!i_nrst)
        (st.cfg.sync_edge_select && $rose(i_frame_sync)) |-> !sync_edge;
    endproperty
    a_falling_only: assert property (p_falling_only) // R1
        else $error("rising edge taken in falling mode");

    property p_free_no_restart;
        @(posedge i_clk) disable iff (!i_nrst)
        (st.cfg.free_count_select && sync_edge && count != 16'h0000
            && count != 16'hffff) |=> count != 16'h0000;
    endproperty
    a_free_no_restart: assert property (p_free_no_restart) // R4
        else $error("free counting restarted");

    property p_config_readback;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_rd && i_addr == rptc_pkg::ADDR_CONFIG)
        |=> (o_rdata == $past(st.cfg)) && !o_rdata[7] && !o_rdata[2];
    endproperty
    a_config_readback: assert property (p_config_readback) // R9
        else $error("config read wrong or reserved bit set");

    property p_early_ready;
        @(posedge i_clk) disable iff (!i_nrst)
        (st.cfg.early_ready_select && all_valid && !st.ctl.capture_hold
            && !hold_set && !timer_restart) |=> st.ready;
    endproperty
    a_early_ready: assert property (p_early_ready) // R3
        else $error("early ready not raised");

    // R15: held flags move only on the releasing write
    property p_hold_valid;
        @(posedge i_clk) disable iff (!i_nrst)
        (st.ctl.capture_hold && !(i_wr && i_addr == rptc_pkg::ADDR_CONTROL))
        |=> $stable(valid);
    endproperty
    a_hold_valid: assert property (p_hold_valid) // R15
        else $error("valid flags changed while held");

    // R3: in frame-sync mode, normal ready rises only at an active edge
    property p_normal_ready;
        @(posedge i_clk) disable iff (!i_nrst)
        (!st.ready && !st.cfg.early_ready_select && !st.cfg.free_count_select
            && !timer_restart) |=> !st.ready;
    endproperty
    a_normal_ready: assert property (p_normal_ready) // R3
        else $error("normal ready rose without a sync edge");

    property p_irq_level;
        @(posedge i_clk) disable iff (!i_nrst)
        o_irq == (|(st.int_status & st.int_mask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level disagrees with status and mask");
endmodule
`default_nettype wire

// *** test/rptc_vid_model.sv ***
// Purpose: Video timing and frame-sync source standing for the receive ports.
// Assumes: One frame per start pulse, same events on all four ports.
// Notes: Sync pulse is three cycles wide; lines follow every 8 cycles.
`default_nettype none
module rptc_vid_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Frame request
    input wire logic i_start,
    input wire logic i_pol,
    input wire logic [15:0] i_dly,
    input wire logic [15:0] i_lines,
    // Video timing
    output var rptc_pkg::rptc_port_evt_type [3:0] o_evt,
    output logic o_fs,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int t;
    int k;
    // Frame time in cycles since the start pulse, zero when idle
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            t <= 0;
        else if (i_start)
            t <= 1;
        else if (t != 0 && t < int'(i_dly) + 8 * int'(i_lines) + 4)
            t <= t + 1;
        else
            t <= 0;
    end
    // idles at the inactive level so each frame has one active edge
    assign o_fs = i_pol ^ (t inside {[1:3]});
    assign o_busy = (t != 0);
    // lines counted from frame start, first line is line 1
    always_comb
    begin
        k = t - int'(i_dly);
        for (int p = 0; p < 4; p++)
        begin
            o_evt[p].frame_start = (t != 0) && (k == 0);
            o_evt[p].line_start = (t != 0) && k > 0 && k % 8 == 0 && k / 8 <= int'(i_lines);
        end
    end
endmodule
`default_nettype wire

// *** test/rptc_top_tb.sv ***
// Purpose: Self-checking bench of the timestamp capture unit.
// Assumes: Read data stands one cycle after the read strobe.
// Notes: Captures land mid-step so a one-cycle skew cannot change a stamp.
`default_nettype none
module rptc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [7:0] exp; logic [7:0] msk; } rptc_note_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] rdata;
    rptc_pkg::rptc_port_evt_type [3:0] evt;
    logic fs;
    logic irq;
    logic start = 1'b0;
    logic pol = 1'b0;
    logic [15:0] dly = 16'h0010;
    logic [15:0] lines = 16'h0000;
    logic busy;
    logic [15:0] last2 = 16'h0000;
    logic [15:0] s1;
    logic [7:0] v;
    int cyc = 0;
    int fstart = 0;
    int n_errors = 0;
    int comparisons = 0;
    int steps[4] = '{4, 8, 16, 100};
    rptc_note_type notes[$];
    rptc_note_type nt;

    always #5 clk = ~clk;

    rptc_top rptc_top_inst
    (
        .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_port_evt(evt), .i_frame_sync(fs), .o_irq(irq)
    );
    rptc_vid_model rptc_vid_model_inst
    (
        .i_clk(clk), .i_nrst(nrst), .i_start(start), .i_pol(pol), .i_dly(dly),
        .i_lines(lines), .o_evt(evt), .o_fs(fs), .o_busy(busy)
    );

    task automatic summarize();
        if (n_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // Read answers are matched to the oldest note; a zero mask only records
    always @(posedge clk)
    begin
        if (rd_q)
        begin
            nt = notes.pop_front();
            last2 <= {last2[7:0], rdata};
            if (nt.msk != 8'h00)
                chk(16'(rdata & nt.msk), 16'(nt.exp));
        end
        rd_q <= rd;
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            n_errors++;
            summarize();
        end
    end

    // Gap cycle after each strobe so no strobe is assigned twice at one edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({e, m});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_stamp(input int p, input logic [15:0] e, input logic [7:0] m);
        rd_reg(8'(8'h2a + 2 * p), e[15:8], m);
        rd_reg(8'(8'h2b + 2 * p), e[7:0], m);
        @(posedge clk);
    endtask

    task automatic run_frame(input int d, input int n);
        dly <= 16'(d);
        lines <= 16'(n);
        start <= 1'b1;
        @(posedge clk);
        fstart = cyc;
        start <= 1'b0;
        @(posedge clk);
        while (busy)
            @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(78328));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values, writable bits, unmapped and read-only places
        rd_reg(8'h25, 8'h00, 8'hff);
        rd_reg(8'h26, 8'h00, 8'hff);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            wr_reg(8'h25, v);
            rd_reg(8'h25, v & 8'h7b, 8'hff);
            wr_reg(8'h26, v & 8'h0f);
            rd_reg(8'h26, v & 8'h0f, 8'hff);
        end
        wr_reg(8'h40, 8'hff);
        rd_reg(8'h40, 8'h00, 8'hff);
        wr_reg(8'h29, 8'hff);
        rd_reg(8'h29, 8'h00, 8'hff);
        // Every step code, captured three and a half steps after restart
        wr_reg(8'h26, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(8'h25, 8'(8'h01 | (c << 4)));
            run_frame(steps[c] * 7 / 2 + 2, 0);
            rd_stamp(0, 16'h0003, 8'hff);
        end
        // Falling sync edge; the late rising edge must not restart
        wr_reg(8'h34, 8'h03);
        wr_reg(8'h25, 8'h41);
        pol <= 1'b1;
        run_frame(16, 0);
        rd_stamp(0, 16'h0003, 8'hff);
        // Sticky sync event: masked, raised, then cleared by writing one
        rd_reg(8'h34, 8'h02, 8'h02);
        @(posedge clk);
        chk(16'(irq), 16'h0000);
        wr_reg(8'h35, 8'h02);
        @(posedge clk);
        chk(16'(irq), 16'h0001);
        wr_reg(8'h34, 8'h03);
        @(posedge clk);
        chk(16'(irq), 16'h0000);
        rd_reg(8'h34, 8'h00, 8'h02);
        wr_reg(8'h35, 8'h00);
        // Early ready on ports 0 and 2, then hold and release
        wr_reg(8'h25, 8'h09);
        pol <= 1'b0;
        wr_reg(8'h26, 8'h05);
        run_frame(16, 0);
        rd_reg(8'h29, 8'h15, 8'hff);
        rd_stamp(1, 16'h0000, 8'hff);
        wr_reg(8'h26, 8'h15);
        rd_reg(8'h29, 8'h05, 8'hff);
        run_frame(58, 0);
        rd_stamp(0, 16'h0003, 8'hff);
        // hold cleared only after the stamps were read
        wr_reg(8'h26, 8'h05);
        rd_reg(8'h29, 8'h00, 8'hff);
        // Normal ready waits for the next sync edge
        wr_reg(8'h25, 8'h01);
        wr_reg(8'h26, 8'h01);
        run_frame(16, 0);
        rd_reg(8'h29, 8'h01, 8'hff);
        run_frame(16, 0);
        rd_reg(8'h29, 8'h11, 8'hff);
        // line number above one; line 259 spans both stamp bytes
        wr_reg(8'h25, 8'h00);
        wr_reg(8'h27, 8'h01);
        wr_reg(8'h28, 8'h03);
        run_frame(4, 260);
        rd_stamp(0, 16'h0206, 8'hff);
        // Free counting runs on across the sync edge of the second frame
        wr_reg(8'h25, 8'h02);
        wr_reg(8'h27, 8'h00);
        run_frame(4, 4);
        rd_stamp(0, 16'h0000, 8'h00);
        s1 = last2;
        while (cyc != fstart + 399)
            @(posedge clk);
        run_frame(4, 4);
        rd_stamp(0, 16'h0000, 8'h00);
        chk(last2 - s1, 16'h0064);
        // Free frame mode: a frame start counts only after a frame reached the line
        wr_reg(8'h25, 8'h03);
        run_frame(4, 2);
        wr_reg(8'h26, 8'h11);
        wr_reg(8'h26, 8'h01);
        run_frame(4, 2);
        rd_reg(8'h29, 8'h00, 8'hff);
        run_frame(4, 4);
        run_frame(4, 2);
        rd_reg(8'h29, 8'h11, 8'hff);
        summarize();
    end
endmodule
`default_nettype wire
